// *** design/tx_port_pkg.sv ***
package tx_port_pkg;

  // APB register byte addresses.
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_BLOCK_MASK = 12'h004;
  localparam logic [11:0] ADDR_GATE_MASK = 12'h008;
  localparam logic [11:0] ADDR_LINK_DIV = 12'h00C;
  localparam logic [11:0] ADDR_SA_MASK = 12'h010;
  localparam logic [11:0] ADDR_STATUS = 12'h014;

  // Reset values.
  localparam logic [11:0] CTRL_RESET = 12'h000;
  localparam logic [31:0] MASK_RESET = 32'h0000_0000;
  localparam logic [8:0] LINK_DIV_RESET = 9'h100;
  localparam logic [4:0] SA_MASK_RESET = 5'h01;
  localparam int CTRL_WIDTH = 12;

  // Control word, bit 0 is e1_mode and bit 11 is formatter_from_rx.
  typedef struct packed {
    logic formatter_from_rx;
    logic liu_connect_bit;
    logic chclk_gated;
    logic zero_byte_substitution;
    logic sig_en;
    logic link_en;
    logic double_wide;
    logic sync_multiframe;
    logic sync_output;
    logic nrz_format;
    logic store_en;
    logic e1_mode;
  } ctrl_s;

  // Frame geometry.
  localparam logic [2:0] LSB_BIT = 3'h7;
  localparam logic [4:0] T1_LAST_CHAN = 5'h17;
  localparam logic [4:0] E1_LAST_CHAN = 5'h1F;
  localparam logic [3:0] T1_LAST_FRAME = 4'hB;
  localparam logic [3:0] E1_LAST_FRAME = 4'hF;
  localparam logic [3:0] T1_SIG_FRAME_A = 4'h5;
  localparam logic [3:0] T1_SIG_FRAME_B = 4'hB;
  localparam logic [2:0] SA_FIRST_BIT = 3'h3;

  // Link clock half periods counted in bit times.
  localparam logic [8:0] T1_LINK_HALF = 9'h0C1;
  localparam logic [8:0] T1_ZBS_LINK_HALF = 9'h182;

  // Index of each external pin in the synchroniser vector.
  localparam int NUM_PINS = 12;
  localparam int PIN_LINE_CLK = 0;
  localparam int PIN_SYS_CLK = 1;
  localparam int PIN_RX_CLK = 2;
  localparam int PIN_LIU_CLK = 3;
  localparam int PIN_SERIAL = 4;
  localparam int PIN_SIG = 5;
  localparam int PIN_LINK = 6;
  localparam int PIN_FSYNC = 7;
  localparam int PIN_SSYNC = 8;
  localparam int PIN_LIU_POS = 9;
  localparam int PIN_LIU_NEG = 10;
  localparam int PIN_BYPASS = 11;

  // Timing: the pclk rate and the synchroniser latency in cycles.
  localparam int PCLK_HZ = 200_000_000;
  localparam int SYNC_STAGES = 3;

  // Position of the backplane counters inside a frame.
  typedef enum logic [1:0] {
    SLOT_FBIT = 2'b00,
    SLOT_PAYLOAD = 2'b01,
    SLOT_LSB = 2'b10,
    SLOT_IDLE = 2'b11
  } slot_e;

endpackage

// *** design/pin_sync.sv ***
`timescale 1ns/1ps
module pin_sync
  import tx_port_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [NUM_PINS-1:0] pins_in,
  output logic [NUM_PINS-1:0] level,
  output logic [NUM_PINS-1:0] rise,
  output logic [NUM_PINS-1:0] fall
);

  logic [NUM_PINS-1:0] s1_q;
  logic [NUM_PINS-1:0] s2_q;
  logic [NUM_PINS-1:0] s3_q;
  logic [NUM_PINS-1:0] level_q;
  logic [NUM_PINS-1:0] level_d;

  genvar i;
  generate
    for (i = 0; i < NUM_PINS; i++) begin : g_pin
      // A change is accepted only once stages two and three agree.
      assign level_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : level_q[i];
      assign rise[i] = level_d[i] & ~level_q[i];
      assign fall[i] = ~level_d[i] & level_q[i];
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      level_q <= '0;
    end else begin
      s1_q <= pins_in;
      s2_q <= s1_q;
      s3_q <= s2_q;
      level_q <= level_d;
    end
  end

  assign level = level_q;

endmodule

// *** design/tx_backplane_port.sv ***
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module tx_backplane_port
  import tx_port_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic tx_line_clock,
  input wire logic tx_system_clock,
  input wire logic rx_framer_clock_in,
  input wire logic tx_serial_in,
  input wire logic tx_signalling_in,
  input wire logic tx_link_in,
  input wire logic tx_system_sync,
  input wire logic tx_frame_sync_in,
  output logic tx_frame_sync_out,
  output logic tx_frame_sync_oe,
  output logic tx_channel_clock,
  output logic tx_channel_block,
  output logic tx_link_clock,
  output logic tx_pos_out,
  output logic tx_neg_out,
  output logic tx_clock_out,
  input wire logic liu_clock_in,
  input wire logic liu_pos_in,
  input wire logic liu_neg_in,
  input wire logic liu_bypass_pin,
  output logic line_pos_out,
  output logic line_neg_out
);

  // Pin synchronisers.
  logic [NUM_PINS-1:0] pins;
  logic [NUM_PINS-1:0] lvl;
  logic [NUM_PINS-1:0] rise;
  logic [NUM_PINS-1:0] fall;

  assign pins[PIN_LINE_CLK] = tx_line_clock;
  assign pins[PIN_SYS_CLK] = tx_system_clock;
  assign pins[PIN_RX_CLK] = rx_framer_clock_in;
  assign pins[PIN_LIU_CLK] = liu_clock_in;
  assign pins[PIN_SERIAL] = tx_serial_in;
  assign pins[PIN_SIG] = tx_signalling_in;
  assign pins[PIN_LINK] = tx_link_in;
  assign pins[PIN_FSYNC] = tx_frame_sync_in;
  assign pins[PIN_SSYNC] = tx_system_sync;
  assign pins[PIN_LIU_POS] = liu_pos_in;
  assign pins[PIN_LIU_NEG] = liu_neg_in;
  assign pins[PIN_BYPASS] = liu_bypass_pin;

  // Clocks and data share the same latency, so a data pin seen at a clock edge
  // holds the value it had at that edge on the wire.
  pin_sync u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pins_in(pins),
    .level(lvl),
    .rise(rise),
    .fall(fall)
  );

  // Registers.
  ctrl_s ctrl_q;
  logic [31:0] block_mask_q;
  logic [31:0] gate_mask_q;
  logic [8:0] link_div_q;
  logic [4:0] sa_mask_q;
  logic [31:0] prdata_q;
  logic [31:0] status_w;
  logic [31:0] rd_mux;

  wire sel_ctrl = (paddr == ADDR_CTRL);
  wire sel_block = (paddr == ADDR_BLOCK_MASK);
  wire sel_gate = (paddr == ADDR_GATE_MASK);
  wire sel_div = (paddr == ADDR_LINK_DIV);
  wire sel_sa = (paddr == ADDR_SA_MASK);
  wire sel_status = (paddr == ADDR_STATUS);
  wire mapped = sel_ctrl | sel_block | sel_gate | sel_div | sel_sa | sel_status;
  wire access = psel & penable;
  wire wr_en = access & pwrite & mapped & ~sel_status;

  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  assign prdata = prdata_q;

  assign rd_mux = sel_ctrl ? {20'h00000, ctrl_q} :
                  sel_block ? block_mask_q :
                  sel_gate ? gate_mask_q :
                  sel_div ? {23'h000000, link_div_q} :
                  sel_sa ? {27'h0000000, sa_mask_q} :
                  sel_status ? status_w : 32'h0000_0000;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= ctrl_s'(CTRL_RESET);
      block_mask_q <= MASK_RESET;
      gate_mask_q <= MASK_RESET;
      link_div_q <= LINK_DIV_RESET;
      sa_mask_q <= SA_MASK_RESET;
      prdata_q <= 32'h0000_0000;
    end else begin
      if (wr_en && sel_ctrl) begin
        ctrl_q <= ctrl_s'(pwdata[CTRL_WIDTH-1:0]);
      end
      if (wr_en && sel_block) begin
        block_mask_q <= pwdata;
      end
      if (wr_en && sel_gate) begin
        gate_mask_q <= pwdata;
      end
      if (wr_en && sel_div) begin
        link_div_q <= pwdata[8:0];
      end
      if (wr_en && sel_sa) begin
        sa_mask_q <= pwdata[4:0];
      end
      // Read data is captured in the setup cycle and stands through access.
      if (psel && !penable) begin
        prdata_q <= rd_mux;
      end
    end
  end

  // Backplane timing domain: line clock, or system clock with the store on.
  wire bp_rise = ctrl_q.store_en ? rise[PIN_SYS_CLK] : rise[PIN_LINE_CLK];
  wire bp_fall = ctrl_q.store_en ? fall[PIN_SYS_CLK] : fall[PIN_LINE_CLK];
  wire bp_level = ctrl_q.store_en ? lvl[PIN_SYS_CLK] : lvl[PIN_LINE_CLK];

  // With the store off the system sync pin is ignored, so a stray level there
  // cannot move the frame.
  wire sync_in_pulse = ctrl_q.store_en ? rise[PIN_SSYNC] :
                       (~ctrl_q.sync_output & rise[PIN_FSYNC]);

  // Frame position counters.
  logic [2:0] bit_q;
  logic [4:0] chan_q;
  logic [3:0] frame_q;
  logic fbit_q;
  slot_e slot;

  wire [4:0] last_chan = ctrl_q.e1_mode ? E1_LAST_CHAN : T1_LAST_CHAN;
  wire [3:0] last_frame = ctrl_q.e1_mode ? E1_LAST_FRAME : T1_LAST_FRAME;
  wire chan_end = (bit_q == LSB_BIT);
  wire frame_end = chan_end & (chan_q == last_chan);

  always_comb begin
    case ({fbit_q, chan_end})
      2'b00: slot = SLOT_PAYLOAD;
      2'b01: slot = SLOT_LSB;
      2'b10: slot = SLOT_FBIT;
      2'b11: slot = SLOT_FBIT;
      default: slot = SLOT_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bit_q <= 3'h0;
      chan_q <= 5'h00;
      frame_q <= 4'h0;
      fbit_q <= 1'b1;
    end else if (sync_in_pulse) begin
      bit_q <= 3'h0;
      chan_q <= 5'h00;
      fbit_q <= ~ctrl_q.e1_mode;
      if (ctrl_q.sync_multiframe) begin
        frame_q <= 4'h0;
      end
    end else if (bp_rise) begin
      if (slot == SLOT_FBIT) begin
        fbit_q <= 1'b0;
        bit_q <= 3'h0;
        chan_q <= 5'h00;
      end else if (frame_end) begin
        bit_q <= 3'h0;
        chan_q <= 5'h00;
        fbit_q <= ~ctrl_q.e1_mode;
        frame_q <= (frame_q == last_frame) ? 4'h0 : frame_q + 4'h1;
      end else if (chan_end) begin
        bit_q <= 3'h0;
        chan_q <= chan_q + 5'h01;
      end else begin
        bit_q <= bit_q + 3'h1;
      end
    end
  end

  // Serial and signalling capture, MSB first.
  logic [7:0] ser_shift_q;
  logic [7:0] sig_shift_q;
  logic [7:0] last_byte_q;
  logic [7:0] last_sig_q;
  logic ser_bit_q;

  wire in_payload = (slot != SLOT_FBIT);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ser_shift_q <= 8'h00;
      sig_shift_q <= 8'h00;
      last_byte_q <= 8'h00;
      last_sig_q <= 8'h00;
      ser_bit_q <= 1'b0;
    end else if (bp_fall) begin
      ser_bit_q <= lvl[PIN_SERIAL];
      if (in_payload) begin
        ser_shift_q <= {ser_shift_q[6:0], lvl[PIN_SERIAL]};
        if (ctrl_q.sig_en) begin
          sig_shift_q <= {sig_shift_q[6:0], lvl[PIN_SIG]};
        end
        if (chan_end) begin
          last_byte_q <= {ser_shift_q[6:0], lvl[PIN_SERIAL]};
          if (ctrl_q.sig_en) begin
            last_sig_q <= {sig_shift_q[6:0], lvl[PIN_SIG]};
          end
        end
      end
    end
  end

  // Link data lands in the T1 F-bit slot or in the chosen E1 Sa bits of slot 0.
  logic link_bit_q;
  logic link_clk_q;
  logic [8:0] link_cnt_q;
  wire [2:0] sa_idx = bit_q - SA_FIRST_BIT;
  wire sa_slot = (chan_q == 5'h00) & (bit_q >= SA_FIRST_BIT) & frame_q[0] & sa_mask_q[sa_idx];
  wire link_slot = ctrl_q.e1_mode ? sa_slot : fbit_q;
  wire [8:0] link_half = ctrl_q.e1_mode ? link_div_q :
                         (ctrl_q.zero_byte_substitution ? T1_ZBS_LINK_HALF : T1_LINK_HALF);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_bit_q <= 1'b0;
      link_clk_q <= 1'b0;
      link_cnt_q <= 9'h000;
    end else begin
      if (ctrl_q.link_en && fall[PIN_LINE_CLK] && link_slot) begin
        link_bit_q <= lvl[PIN_LINK];
      end
      if (sync_in_pulse) begin
        link_cnt_q <= 9'h000;
        link_clk_q <= 1'b0;
      end else if (bp_rise) begin
        if (link_cnt_q + 9'h001 >= link_half) begin
          link_cnt_q <= 9'h000;
          link_clk_q <= ~link_clk_q;
        end else begin
          link_cnt_q <= link_cnt_q + 9'h001;
        end
      end
    end
  end

  assign tx_link_clock = link_clk_q;

  // Channel clock, channel block and frame sync output.
  logic chclk_q;
  logic chblk_q;
  logic fsync_q;

  wire frame_start = ctrl_q.e1_mode ? ((chan_q == 5'h00) & (bit_q == 3'h0)) : fbit_q;
  wire sig_frame = (frame_q == T1_SIG_FRAME_A) | (frame_q == T1_SIG_FRAME_B);
  wire second_bit = ~ctrl_q.e1_mode & ~fbit_q & (chan_q == 5'h00) & (bit_q == 3'h0);
  wire mf_ok = ~ctrl_q.sync_multiframe | (frame_q == 4'h0);
  wire wide_ok = ctrl_q.double_wide & ~ctrl_q.sync_multiframe & sig_frame & second_bit;
  wire chclk_plain = (slot == SLOT_LSB);
  wire chclk_gate = bp_level & gate_mask_q[chan_q] & in_payload;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chclk_q <= 1'b0;
      chblk_q <= 1'b0;
      fsync_q <= 1'b0;
    end else begin
      chclk_q <= ctrl_q.chclk_gated ? chclk_gate : chclk_plain;
      chblk_q <= in_payload & block_mask_q[chan_q];
      fsync_q <= (frame_start & mf_ok) | wide_ok;
    end
  end

  assign tx_channel_clock = chclk_q;
  assign tx_channel_block = chblk_q;
  assign tx_frame_sync_out = fsync_q;
  assign tx_frame_sync_oe = ctrl_q.sync_output;

  // Formatter output: AMI marks alternate polarity, NRZ uses the positive pin.
  wire fmt_rise = ctrl_q.formatter_from_rx ? rise[PIN_RX_CLK] : rise[PIN_LINE_CLK];
  wire fmt_fall = ctrl_q.formatter_from_rx ? fall[PIN_RX_CLK] : fall[PIN_LINE_CLK];
  wire fmt_level = ctrl_q.formatter_from_rx ? lvl[PIN_RX_CLK] : lvl[PIN_LINE_CLK];
  logic pos_q;
  logic neg_q;
  logic mark_pol_q;
  logic clk_out_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pos_q <= 1'b0;
      neg_q <= 1'b0;
      mark_pol_q <= 1'b0;
      clk_out_q <= 1'b0;
    end else begin
      clk_out_q <= (fmt_level | fmt_rise) & ~fmt_fall;
      if (fmt_rise) begin
        if (ctrl_q.nrz_format) begin
          pos_q <= ser_bit_q;
          neg_q <= 1'b0;
        end else begin
          pos_q <= ser_bit_q & ~mark_pol_q;
          neg_q <= ser_bit_q & mark_pol_q;
          if (ser_bit_q) begin
            mark_pol_q <= ~mark_pol_q;
          end
        end
      end
    end
  end

  assign tx_pos_out = pos_q;
  assign tx_neg_out = neg_q;
  assign tx_clock_out = clk_out_q;

  // Line side: the internal path bypasses the interim pins entirely.
  wire connect = lvl[PIN_BYPASS] | ctrl_q.liu_connect_bit;
  wire liu_fall = connect ? fmt_fall : fall[PIN_LIU_CLK];
  wire liu_pos = connect ? pos_q : lvl[PIN_LIU_POS];
  wire liu_neg = connect ? neg_q : lvl[PIN_LIU_NEG];
  logic line_pos_q;
  logic line_neg_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      line_pos_q <= 1'b0;
      line_neg_q <= 1'b0;
    end else if (liu_fall) begin
      line_pos_q <= liu_pos;
      line_neg_q <= liu_neg;
    end
  end

  assign line_pos_out = line_pos_q;
  assign line_neg_out = line_neg_q;

  assign status_w = {frame_q, chan_q, bit_q, fbit_q, connect, link_bit_q, mark_pol_q,
                     last_sig_q, last_byte_q};

endmodule

// *** tb/tx_backplane_port_sva.sv ***
`timescale 1ns/1ps
module tx_backplane_port_sva
  import tx_port_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic tx_line_clock,
  input wire logic liu_clock_in,
  input wire logic liu_bypass_pin,
  input wire logic tx_frame_sync_out,
  input wire logic tx_frame_sync_oe,
  input wire logic tx_channel_clock,
  input wire logic tx_link_clock,
  input wire logic tx_pos_out,
  input wire logic tx_neg_out,
  input wire logic tx_clock_out,
  input wire logic line_pos_out
);
  ctrl_s ctrl_q;
  logic [15:0] ch_q;
  logic [15:0] fs_q;
  logic [15:0] gap_q;
  logic lk_q;
  logic ok_q;
  logic ctrl_wr;
  logic lk_t;
  assign ctrl_wr = psel && penable && pwrite && paddr == ADDR_CTRL;
  assign lk_t = tx_link_clock != lk_q;
  // The control word is shadowed from the bus so the checker needs no internal probe.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= '0;
      ch_q <= 16'h0;
      fs_q <= 16'h0;
      gap_q <= 16'h0;
      lk_q <= 1'b0;
      ok_q <= 1'b0;
    end else begin
      if (ctrl_wr) ctrl_q <= ctrl_s'(pwdata[CTRL_WIDTH-1:0]);
      ch_q <= tx_channel_clock ? ch_q + 16'h1 : 16'h0;
      fs_q <= tx_frame_sync_out ? fs_q + 16'h1 : 16'h0;
      gap_q <= lk_t ? 16'h1 : gap_q + 16'h1;
      lk_q <= tx_link_clock;
      ok_q <= !ctrl_wr && (ok_q || lk_t);
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  property p_clk_follow;
    $rose(tx_line_clock) && !ctrl_q.formatter_from_rx |-> ##[2:8] tx_clock_out;
  endproperty
  a_clk_follow: assert property (p_clk_follow) else $error("clock out lost line clock");
  property p_pos_upd;
    $changed(tx_pos_out) || $changed(tx_neg_out) |-> tx_clock_out || $past(tx_clock_out);
  endproperty
  a_pos_upd: assert property (p_pos_upd) else $error("data moved off clock rise");
  property p_ami;
    !ctrl_q.nrz_format |-> !(tx_pos_out && tx_neg_out);
  endproperty
  a_ami: assert property (p_ami) else $error("both rails high");
  property p_line_smp;
    $changed(line_pos_out) && !liu_bypass_pin && !$past(liu_bypass_pin, 8) && !ctrl_q.liu_connect_bit
      |-> !liu_clock_in;
  endproperty
  a_line_smp: assert property (p_line_smp) else $error("line data moved while clock high");
  property p_oe;
    tx_frame_sync_oe == ctrl_q.sync_output;
  endproperty
  a_oe: assert property (p_oe) else $error("sync direction wrong");
  property p_chclk_w;
    !ctrl_q.chclk_gated && !ctrl_q.store_en |-> ch_q <= 16'h28;
  endproperty
  a_chclk_w: assert property (p_chclk_w) else $error("channel clock too wide");
  property p_fs_w;
    fs_q <= (ctrl_q.double_wide ? 16'h48 : 16'h28);
  endproperty
  a_fs_w: assert property (p_fs_w) else $error("sync pulse too wide");
  property p_link;
    lk_t && ok_q && !ctrl_q.e1_mode && !ctrl_q.zero_byte_substitution |-> gap_q inside {[16'h181C:16'h1824]};
  endproperty
  a_link: assert property (p_link) else $error("link clock half period wrong");
endmodule

bind tx_backplane_port tx_backplane_port_sva u_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .tx_line_clock(tx_line_clock),
  .liu_clock_in(liu_clock_in), .liu_bypass_pin(liu_bypass_pin), .tx_frame_sync_out(tx_frame_sync_out),
  .tx_frame_sync_oe(tx_frame_sync_oe), .tx_channel_clock(tx_channel_clock), .tx_link_clock(tx_link_clock),
  .tx_pos_out(tx_pos_out), .tx_neg_out(tx_neg_out), .tx_clock_out(tx_clock_out),
  .line_pos_out(line_pos_out));

// *** tb/backplane_model.sv ***
`timescale 1ns/1ps
module backplane_model (
  output logic tx_line_clock,
  output logic tx_serial_in,
  output logic tx_signalling_in,
  output logic tx_system_clock,
  output logic tx_system_sync
);
  logic [7:0] pattern;
  logic [2:0] idx;
  logic prev_bit;
  // Data changes on the rising edge so it is stable when the falling edge samples it.
  initial begin
    pattern = 8'hA5;
    idx = 3'h0;
    prev_bit = 1'b0;
    tx_line_clock = 1'b0;
    tx_serial_in = 1'b0;
    tx_signalling_in = 1'b1;
    tx_system_clock = 1'b0;
    tx_system_sync = 1'b0;
    #3;
    forever begin
      #80 tx_line_clock = 1'b1;
      prev_bit = tx_serial_in;
      tx_serial_in = pattern[3'h7 - idx];
      tx_signalling_in = ~tx_serial_in;
      idx = idx + 3'h1;
      #80 tx_line_clock = 1'b0;
    end
  end
endmodule

// *** tb/test_t1e1_transmit_backplane_port.sv ***
`timescale 1ns/1ps
module test_t1e1_transmit_backplane_port
  import tx_port_pkg::*;
;
  localparam int FRM = 193 * 32;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic lclk, ser, sig, sclk, ssync, lp, ln, byp, fs_out, fs_oe;
  logic chclk, chblk, lkclk, pos, neg, clko, lpos, lneg, pp;
  logic fsi, rxc;
  int fails = 0;
  int num_checks = 0;
  int n;
  backplane_model m (.tx_line_clock(lclk), .tx_serial_in(ser), .tx_signalling_in(sig),
    .tx_system_clock(sclk), .tx_system_sync(ssync));
  tx_backplane_port dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .tx_line_clock(lclk), .tx_system_clock(sclk), .rx_framer_clock_in(rxc),
    .tx_serial_in(ser), .tx_signalling_in(sig), .tx_link_in(1'b0), .tx_system_sync(ssync),
    .tx_frame_sync_in(fsi), .tx_frame_sync_out(fs_out), .tx_frame_sync_oe(fs_oe),
    .tx_channel_clock(chclk), .tx_channel_block(chblk), .tx_link_clock(lkclk), .tx_pos_out(pos),
    .tx_neg_out(neg), .tx_clock_out(clko), .liu_clock_in(lclk), .liu_pos_in(lp), .liu_neg_in(ln),
    .liu_bypass_pin(byp), .line_pos_out(lpos), .line_neg_out(lneg));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic waitfor(ref logic s, input logic v);
    int k;
    k = 0;
    while (s !== v && k < 20000) begin
      @(posedge pclk);
      k++;
    end
    if (k == 20000) fails++;
  endtask
  task automatic t_regs;
    apb(0, ADDR_CTRL, 0); chk(rd, {20'h0, CTRL_RESET});
    apb(0, ADDR_LINK_DIV, 0); chk(rd, {23'h0, LINK_DIV_RESET});
    apb(0, ADDR_SA_MASK, 0); chk(rd, {27'h0, SA_MASK_RESET});
    apb(0, ADDR_BLOCK_MASK, 0); chk(rd, MASK_RESET);
    apb(1, ADDR_GATE_MASK, 32'h0000_00F0);
    apb(0, ADDR_GATE_MASK, 0); chk(rd, 32'h0000_00F0);
    apb(0, 12'h018, 0); chk({rd[30:0], err}, 32'h1);
  endtask
  task automatic t_frame;
    logic fp, cp;
    int nch, nblk;
    apb(1, ADDR_BLOCK_MASK, 32'h1);
    apb(1, ADDR_CTRL, 32'h8);
    apb(0, ADDR_CTRL, 0); chk(rd, 32'h8);
    waitfor(fs_out, 1'b0);
    waitfor(fs_out, 1'b1);
    chk(fs_oe, 1);
    fp = 1'b1;
    n = 0;
    nch = 0;
    nblk = 0;
    while (!(fs_out === 1'b1 && fp === 1'b0) && n < 8000) begin
      fp = fs_out;
      cp = chclk;
      @(posedge pclk);
      n++;
      if (chclk === 1'b1 && cp === 1'b0) nch++;
      if (chblk === 1'b1) nblk++;
    end
    chk(n inside {[FRM-3:FRM+3]}, 1);
    chk(nch, 24);
    chk(nblk inside {[253:259]}, 1);
  endtask
  task automatic t_link;
    logic v;
    v = lkclk;
    waitfor(lkclk, ~v);
    v = lkclk;
    n = 0;
    while (lkclk === v && n < 20000) begin
      @(posedge pclk);
      n++;
    end
    chk(n inside {[FRM-3:FRM+3]}, 1);
  endtask
  task automatic rise(ref logic s);
    waitfor(s, 1'b0);
    waitfor(s, 1'b1);
    repeat (4) @(posedge pclk);
  endtask
  task automatic t_ami;
    m.pattern = 8'hFF;
    apb(1, ADDR_CTRL, 32'h0);
    repeat (3) rise(clko);
    pp = pos;
    for (int i = 0; i < 6; i++) begin
      rise(clko);
      chk({pos, neg}, {~pp, pp});
      pp = pos;
    end
  endtask
  task automatic t_nrz;
    m.pattern = 8'hA5;
    apb(1, ADDR_CTRL, 32'h4);
    for (int i = 0; i < 16; i++) begin
      rise(clko);
      chk(pos, m.prev_bit);
    end
  endtask
  task automatic t_clksel;
    // The receive framer clock is held still, so selecting it must freeze the formatter.
    apb(1, ADDR_CTRL, 32'h800);
    pp = pos;
    repeat (64) @(posedge pclk);
    chk({clko, pos}, {1'b0, pp});
    rxc <= 1'b1;
    repeat (6) @(posedge pclk);
    chk(clko, 1);
    rxc <= 1'b0;
    repeat (6) @(posedge pclk);
    chk(clko, 0);
    apb(1, ADDR_CTRL, 32'h0);
    waitfor(clko, 1'b1);
    chk(clko, 1);
  endtask
  task automatic t_line;
    for (int i = 0; i < 2; i++) begin
      rise(lclk);
      lp <= ~i[0];
      ln <= i[0];
      waitfor(lclk, 1'b0);
      waitfor(lclk, 1'b1);
      chk({lpos, lneg}, {~i[0], i[0]});
    end
    m.pattern = 8'hFF;
    byp <= 1'b1;
    lp <= 1'b0;
    ln <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      waitfor(clko, 1'b1);
      waitfor(clko, 1'b0);
      repeat (4) @(posedge pclk);
      chk({lpos, lneg}, {pos, neg});
    end
  endtask
  task automatic t_sync;
    waitfor(fs_out, 1'b1);
    waitfor(fs_out, 1'b0);
    // The control writes around the pulse restart the link period watch, as the pulse restarts the link clock.
    apb(1, ADDR_CTRL, 32'h0);
    fsi <= 1'b1;
    n = 0;
    while (fs_out !== 1'b1 && n < 64) begin
      @(posedge pclk);
      n++;
    end
    fsi <= 1'b0;
    chk(n inside {[5:7]}, 1);
    apb(1, ADDR_CTRL, 32'h0);
  endtask
  task automatic t_gate;
    logic cp;
    int nch;
    apb(1, ADDR_CTRL, 32'h200);
    waitfor(fs_out, 1'b1);
    waitfor(fs_out, 1'b0);
    nch = 0;
    n = 0;
    while (fs_out !== 1'b1 && n < 8000) begin
      cp = chclk;
      @(posedge pclk);
      n++;
      if (chclk === 1'b1 && cp === 1'b0) nch++;
    end
    chk(nch, 32);
  endtask
  task automatic wrap_up;
    $display("checks=%0d fails=%0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  initial begin
    #400000;
    fails++;
    wrap_up();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    lp = 1'b0;
    ln = 1'b0;
    byp = 1'b0;
    fsi = 1'b0;
    rxc = 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    t_regs();
    t_frame();
    t_link();
    t_sync();
    t_gate();
    t_ami();
    t_nrz();
    t_clksel();
    t_line();
    wrap_up();
  end
endmodule
